// ---- common/sws_pkg.sv ----
// Purpose: Shared constants and types for the supervisor window watchdog.
// Assumes: 100 MHz system clock; all times are given in microseconds.
// Notes: Cycle counts are derived from the times; long counts are top parameters.
package sws_pkg;
  localparam int CLK_MHZ = 100;
  localparam int CW = 36;
  typedef logic [CW-1:0] sws_cnt_t;

  // Reset delay nominal times.
  localparam longint RST_OPEN_US = 200000;
  localparam longint RST_PULL_US = 10000;
  localparam longint RST_CAP_US = 10000;
  // Detection sequence and watchdog enable settling time.
  localparam longint DET_US = 381;
  localparam longint SETUP_US = 150;
  // Watchdog lower and upper bounds, timing pin open.
  localparam longint WDL_OPEN_00_US = 22500;
  localparam longint WDU_OPEN_00_US = 55000;
  localparam longint WDL_OPEN_01_US = 1850;
  localparam longint WDU_OPEN_01_US = 27500;
  localparam longint WDL_OPEN_11_US = 800000;
  localparam longint WDU_OPEN_11_US = 1600000;
  // Watchdog lower and upper bounds, timing pin pulled up.
  localparam longint WDL_PULL_00_US = 9000;
  localparam longint WDU_PULL_00_US = 109000;
  localparam longint WDL_PULL_01_US = 9000;
  localparam longint WDU_PULL_01_US = 195000;
  localparam longint WDL_PULL_11_US = 1850;
  localparam longint WDU_PULL_11_US = 11000;
  // Upper bound in capacitor mode; the lower bound follows from the ratio.
  localparam longint WDU_CAP_US = 55000;

  localparam longint RST_OPEN_CYC = RST_OPEN_US * CLK_MHZ;
  localparam longint RST_PULL_CYC = RST_PULL_US * CLK_MHZ;
  localparam longint RST_CAP_CYC = RST_CAP_US * CLK_MHZ;
  localparam longint DET_CYC = DET_US * CLK_MHZ;
  localparam longint SETUP_CYC = SETUP_US * CLK_MHZ;
  localparam longint WDL_OPEN_00_CYC = WDL_OPEN_00_US * CLK_MHZ;
  localparam longint WDU_OPEN_00_CYC = WDU_OPEN_00_US * CLK_MHZ;
  localparam longint WDL_OPEN_01_CYC = WDL_OPEN_01_US * CLK_MHZ;
  localparam longint WDU_OPEN_01_CYC = WDU_OPEN_01_US * CLK_MHZ;
  localparam longint WDL_OPEN_11_CYC = WDL_OPEN_11_US * CLK_MHZ;
  localparam longint WDU_OPEN_11_CYC = WDU_OPEN_11_US * CLK_MHZ;
  localparam longint WDL_PULL_00_CYC = WDL_PULL_00_US * CLK_MHZ;
  localparam longint WDU_PULL_00_CYC = WDU_PULL_00_US * CLK_MHZ;
  localparam longint WDL_PULL_01_CYC = WDL_PULL_01_US * CLK_MHZ;
  localparam longint WDU_PULL_01_CYC = WDU_PULL_01_US * CLK_MHZ;
  localparam longint WDL_PULL_11_CYC = WDL_PULL_11_US * CLK_MHZ;
  localparam longint WDU_PULL_11_CYC = WDU_PULL_11_US * CLK_MHZ;
  localparam longint WDU_CAP_CYC = WDU_CAP_US * CLK_MHZ;

  // Configuration pin classification codes.
  localparam logic [1:0] CFG_OPEN = 2'h0;
  localparam logic [1:0] CFG_PULL = 2'h1;
  localparam logic [1:0] CFG_CAP = 2'h2;
  // Window select as {select_0, select_1}.
  localparam logic [1:0] SEL_DIS = 2'h2;
  localparam logic [1:0] SEL_01 = 2'h1;
  localparam logic [1:0] SEL_11 = 2'h3;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0c;
  localparam int CTRL_FORCE = 0;
  localparam int EV_W = 4;
  localparam int EV_RESET = 0;
  localparam int EV_EARLY = 1;
  localparam int EV_LATE = 2;
  localparam int EV_DET = 3;
  localparam logic [EV_W-1:0] STATUS_RST = 4'h0;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sws_bus_req_t;
endpackage : sws_pkg

// ---- hdl/sws_cfg_detect.sv ----
// Purpose: Timed classification of a configuration pin.
// Assumes: The pad front end presents the pin class as a stable code.
// Notes: The code is latched at the end of the sequence; a new start restarts it.
`timescale 1ns/1ps
module sws_cfg_detect #(
  parameter sws_pkg::sws_cnt_t DET = sws_pkg::sws_cnt_t'(sws_pkg::DET_CYC)
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic [1:0] pin_code,
  output logic [1:0] code,
  output logic done
);
  sws_pkg::sws_cnt_t cnt;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt <= '0;
      done <= 1'b0;
      code <= sws_pkg::CFG_OPEN;
    end else if (start) begin
      cnt <= DET;
      done <= 1'b0;
    end else if (cnt == sws_pkg::sws_cnt_t'(1)) begin
      cnt <= '0;
      done <= 1'b1;
      code <= pin_code;
    end else if (cnt != '0) begin
      cnt <= cnt - sws_pkg::sws_cnt_t'(1);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_detect_load: assert property (start |=> cnt == DET && !done) // R6
    else $error("detection did not load its full length");
  a_detect_end: assert property ($rose(done) |-> $past(cnt) == 1) // R6
    else $error("detection ended early");
endmodule : sws_cfg_detect

// ---- hdl/sws_supervisor.sv ----
// Purpose: Supervisor reset sequencing and window watchdog.
// Assumes: Comparator and pin class inputs come from asynchronous analog pads.
// Notes: Open-drain outputs use an active-low enable; the pad supplies the pullup.
// Overview of operation
// R1: Supply below lockout level keeps reset asserted regardless of sense input.
// R2: While reset is asserted, fault output floats and kick edges are ignored.
// R3: Sense outside valid window asserts reset; inside window releases it.
// R4: Kick falling-edge interval outside lower/upper bounds pulls fault output low.
// R5: Reset delay is 200 ms with pin open, 10 ms with pin pulled up.
// R6: Each reset assertion starts a 381 us reset pin detection sequence.
// R7: Capacitor mode discharges while reset asserted, then times the charge.
// R8: Open or pulled-up timing pin uses factory bounds; capacitor uses its own.
// R9: Open timing pin bounds: 22.5/55, 1.85/27.5, 800/1600 ms; 10 disables.
// R10: Pulled-up bounds: 9/109, 9/195, 1.85/11 ms; selects 10 disable.
// R11: Between lockout and minimum supply, reset still follows the sense input.
// R12: First kick after release needs only beat the upper bound.
// R13: Window timing changes wait for reset; enable and disable act at once.
// R14: After enabling, kick edges are ignored for 150 us.
// R15: Timing pin is re-detected each time sense enters the valid window.
// R16: Capacitor mode times are parameters counted on the internal clock.
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module sws_supervisor #(
  parameter sws_pkg::sws_cnt_t P_RST_OPEN = sws_pkg::sws_cnt_t'(sws_pkg::RST_OPEN_CYC),
  parameter sws_pkg::sws_cnt_t P_RST_PULL = sws_pkg::sws_cnt_t'(sws_pkg::RST_PULL_CYC),
  parameter sws_pkg::sws_cnt_t P_RST_CAP = sws_pkg::sws_cnt_t'(sws_pkg::RST_CAP_CYC),
  parameter sws_pkg::sws_cnt_t P_DET = sws_pkg::sws_cnt_t'(sws_pkg::DET_CYC),
  parameter sws_pkg::sws_cnt_t P_SETUP = sws_pkg::sws_cnt_t'(sws_pkg::SETUP_CYC),
  parameter sws_pkg::sws_cnt_t P_WDL_O00 = sws_pkg::sws_cnt_t'(sws_pkg::WDL_OPEN_00_CYC),
  parameter sws_pkg::sws_cnt_t P_WDU_O00 = sws_pkg::sws_cnt_t'(sws_pkg::WDU_OPEN_00_CYC),
  parameter sws_pkg::sws_cnt_t P_WDL_O01 = sws_pkg::sws_cnt_t'(sws_pkg::WDL_OPEN_01_CYC),
  parameter sws_pkg::sws_cnt_t P_WDU_O01 = sws_pkg::sws_cnt_t'(sws_pkg::WDU_OPEN_01_CYC),
  parameter sws_pkg::sws_cnt_t P_WDL_O11 = sws_pkg::sws_cnt_t'(sws_pkg::WDL_OPEN_11_CYC),
  parameter sws_pkg::sws_cnt_t P_WDU_O11 = sws_pkg::sws_cnt_t'(sws_pkg::WDU_OPEN_11_CYC),
  parameter sws_pkg::sws_cnt_t P_WDL_P00 = sws_pkg::sws_cnt_t'(sws_pkg::WDL_PULL_00_CYC),
  parameter sws_pkg::sws_cnt_t P_WDU_P00 = sws_pkg::sws_cnt_t'(sws_pkg::WDU_PULL_00_CYC),
  parameter sws_pkg::sws_cnt_t P_WDL_P01 = sws_pkg::sws_cnt_t'(sws_pkg::WDL_PULL_01_CYC),
  parameter sws_pkg::sws_cnt_t P_WDU_P01 = sws_pkg::sws_cnt_t'(sws_pkg::WDU_PULL_01_CYC),
  parameter sws_pkg::sws_cnt_t P_WDL_P11 = sws_pkg::sws_cnt_t'(sws_pkg::WDL_PULL_11_CYC),
  parameter sws_pkg::sws_cnt_t P_WDU_P11 = sws_pkg::sws_cnt_t'(sws_pkg::WDU_PULL_11_CYC),
  parameter sws_pkg::sws_cnt_t P_WDU_CAP = sws_pkg::sws_cnt_t'(sws_pkg::WDU_CAP_CYC)
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire sws_pkg::sws_bus_req_t bus,
  output logic [31:0] rd_data,
  input wire logic supply_below_lockout,
  input wire logic sense_below_window,
  input wire logic sense_above_window,
  input wire logic watchdog_kick_in,
  input wire logic window_select_0,
  input wire logic window_select_1,
  input wire logic [1:0] reset_delay_cfg_pin,
  input wire logic [1:0] watchdog_timing_cfg_pin,
  output logic reset_pin_out,
  output logic reset_pin_oe_n,
  output logic watchdog_fault_out,
  output logic watchdog_fault_out_oe_n,
  output logic reset_cap_discharge,
  output logic irq
);
  typedef enum {ST_HOLD, ST_DELAY, ST_RUN} sws_state_t;

  sws_state_t state, next_state;
  logic [9:0] pins_s;
  logic supply_s, under_s, over_s, kick_s;
  logic [1:0] sel_s, rpin_s, wpin_s, rcode, wcode, sel_lat;
  logic kick_prev, kick_fall, fault_cond, in_hold_q, hold_entry, win_entry;
  logic rdet_done, rdet_done_q, wdet_done, wd_live_en, wd_en_q, active;
  logic wd_first, early, late, ctrl_force;
  sws_pkg::sws_cnt_t dly_cnt, dly_cyc, settle_cnt, wd_cnt, lower, upper, fault_cnt;
  logic [sws_pkg::EV_W-1:0] status, mask, events, next_status;

  sws_sync3 #(.W(10)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d({supply_below_lockout, sense_below_window, sense_above_window, watchdog_kick_in,
        window_select_0, window_select_1, reset_delay_cfg_pin, watchdog_timing_cfg_pin}),
    .q(pins_s)
  );
  assign supply_s = pins_s[9];
  assign under_s = pins_s[8];
  assign over_s = pins_s[7];
  assign kick_s = pins_s[6];
  assign sel_s = pins_s[5:4];
  assign rpin_s = pins_s[3:2];
  assign wpin_s = pins_s[1:0];

  // Lockout, either window edge or a software request all count as a fault.
  assign fault_cond = supply_s | under_s | over_s | ctrl_force; // R1 R3 R11
  assign hold_entry = (state == ST_HOLD) && !in_hold_q;
  assign win_entry = (state == ST_HOLD) && !fault_cond;

  sws_cfg_detect #(.DET(P_DET)) u_rdet (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(hold_entry), // R6
    .pin_code(rpin_s),
    .code(rcode),
    .done(rdet_done)
  );

  sws_cfg_detect #(.DET(P_DET)) u_wdet (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(win_entry), // R15
    .pin_code(wpin_s),
    .code(wcode),
    .done(wdet_done)
  );

  function automatic sws_pkg::sws_cnt_t rst_delay(input logic [1:0] c);
    case (c)
      sws_pkg::CFG_OPEN: rst_delay = P_RST_OPEN; // R5
      sws_pkg::CFG_PULL: rst_delay = P_RST_PULL; // R5
      default: rst_delay = P_RST_CAP; // R7 R16
    endcase
  endfunction : rst_delay

  function automatic sws_pkg::sws_cnt_t wd_upper(input logic [1:0] c, input logic [1:0] s);
    if (c == sws_pkg::CFG_OPEN) begin
      wd_upper = (s == sws_pkg::SEL_01) ? P_WDU_O01 : // R9
                 (s == sws_pkg::SEL_11) ? P_WDU_O11 : P_WDU_O00;
    end else if (c == sws_pkg::CFG_PULL) begin
      wd_upper = (s == sws_pkg::SEL_01) ? P_WDU_P01 : // R10
                 (s == sws_pkg::SEL_11) ? P_WDU_P11 : P_WDU_P00;
    end else begin
      wd_upper = P_WDU_CAP; // R8 R16
    end
  endfunction : wd_upper

  function automatic sws_pkg::sws_cnt_t wd_lower(input logic [1:0] c, input logic [1:0] s);
    if (c == sws_pkg::CFG_OPEN) begin
      wd_lower = (s == sws_pkg::SEL_01) ? P_WDL_O01 : // R9
                 (s == sws_pkg::SEL_11) ? P_WDL_O11 : P_WDL_O00;
    end else if (c == sws_pkg::CFG_PULL) begin
      wd_lower = (s == sws_pkg::SEL_01) ? P_WDL_P01 : // R10
                 (s == sws_pkg::SEL_11) ? P_WDL_P11 : P_WDL_P00;
    end else if (s == sws_pkg::SEL_01) begin
      wd_lower = P_WDU_CAP - (P_WDU_CAP >> 2); // R8
    end else if (s == sws_pkg::SEL_11) begin
      wd_lower = P_WDU_CAP >> 1; // R8
    end else begin
      wd_lower = P_WDU_CAP >> 3; // R8
    end
  endfunction : wd_lower

  assign dly_cyc = rst_delay(rcode);
  assign upper = wd_upper(wcode, sel_lat);
  assign lower = wd_lower(wcode, sel_lat);

  always_comb begin
    next_state = state;
    case (state)
      ST_HOLD: begin
        if (!fault_cond) begin
          next_state = ST_DELAY; // R3
        end
      end
      ST_DELAY: begin
        if (fault_cond) begin
          next_state = ST_HOLD;
        end else if (rdet_done && dly_cnt >= dly_cyc - sws_pkg::sws_cnt_t'(1)) begin
          next_state = ST_RUN; // R5 R7
        end
      end
      ST_RUN: begin
        if (fault_cond) begin
          next_state = ST_HOLD; // R1 R3
        end
      end
      default: next_state = ST_HOLD;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_HOLD;
      in_hold_q <= 1'b0;
      rdet_done_q <= 1'b0;
    end else begin
      state <= next_state;
      in_hold_q <= (state == ST_HOLD);
      rdet_done_q <= rdet_done;
    end
  end

  // The delay count waits for the pin class, so a short fault cannot time out early.
  always_ff @(posedge clk_sys) begin
    if (rst || state != ST_DELAY || !rdet_done) begin
      dly_cnt <= '0;
    end else begin
      dly_cnt <= dly_cnt + sws_pkg::sws_cnt_t'(1); // R5 R16
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reset_pin_out <= 1'b0;
      reset_pin_oe_n <= 1'b0;
      reset_cap_discharge <= 1'b0;
    end else begin
      reset_pin_out <= 1'b0;
      reset_pin_oe_n <= (next_state == ST_RUN); // R1 R3
      reset_cap_discharge <= (next_state == ST_HOLD) && (rcode == sws_pkg::CFG_CAP); // R7
    end
  end

  // Window timing is latched only outside run; a disabled latch follows the pins so
  // that enabling picks up the present selection at once.
  assign wd_live_en = (sel_s != sws_pkg::SEL_DIS); // R13
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sel_lat <= sws_pkg::SEL_DIS;
    end else if (state != ST_RUN || sel_lat == sws_pkg::SEL_DIS || !wd_live_en) begin
      sel_lat <= sel_s; // R13
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wd_en_q <= 1'b0;
      settle_cnt <= '0;
    end else begin
      wd_en_q <= wd_live_en;
      if (!wd_live_en) begin
        settle_cnt <= '0;
      end else if (!wd_en_q) begin
        settle_cnt <= P_SETUP; // R14
      end else if (settle_cnt != '0) begin
        settle_cnt <= settle_cnt - sws_pkg::sws_cnt_t'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      kick_prev <= 1'b0;
    end else begin
      kick_prev <= kick_s;
    end
  end
  assign kick_fall = kick_prev && !kick_s;
  assign active = (state == ST_RUN) && wd_live_en && (settle_cnt == '0) && wdet_done; // R2 R14
  assign early = active && kick_fall && !wd_first && (wd_cnt < lower); // R4 R12
  assign late = active && !kick_fall && (wd_cnt >= upper - sws_pkg::sws_cnt_t'(1)); // R4

  always_ff @(posedge clk_sys) begin
    if (rst || !active) begin
      wd_cnt <= '0;
      wd_first <= 1'b1;
    end else if (kick_fall) begin
      wd_cnt <= '0; // R4
      wd_first <= 1'b0;
    end else if (late) begin
      wd_cnt <= '0;
      wd_first <= 1'b1;
    end else begin
      wd_cnt <= wd_cnt + sws_pkg::sws_cnt_t'(1);
    end
  end

  // A fault holds the output low for one reset delay; reset itself floats it.
  always_ff @(posedge clk_sys) begin
    if (rst || next_state != ST_RUN) begin
      fault_cnt <= '0;
      watchdog_fault_out_oe_n <= 1'b1; // R2
    end else if (early || late) begin
      fault_cnt <= dly_cyc; // R4
      watchdog_fault_out_oe_n <= 1'b0;
    end else if (fault_cnt > sws_pkg::sws_cnt_t'(1)) begin
      fault_cnt <= fault_cnt - sws_pkg::sws_cnt_t'(1);
    end else begin
      fault_cnt <= '0;
      watchdog_fault_out_oe_n <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      watchdog_fault_out <= 1'b0;
    end else begin
      watchdog_fault_out <= 1'b0;
    end
  end

  // Register file: a new event wins over a same-cycle write-one clear.
  assign events = {rdet_done && !rdet_done_q, late, early, hold_entry};
  always_comb begin
    next_status = status;
    if (bus.wr && bus.addr == sws_pkg::ADDR_STATUS) begin
      next_status = status & ~bus.wdata[sws_pkg::EV_W-1:0];
    end
    next_status = next_status | events;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status <= sws_pkg::STATUS_RST;
      mask <= sws_pkg::MASK_RST;
      ctrl_force <= 1'b0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      if (bus.wr && bus.addr == sws_pkg::ADDR_MASK) begin
        mask <= bus.wdata[sws_pkg::EV_W-1:0];
      end
      if (bus.wr && bus.addr == sws_pkg::ADDR_CTRL) begin
        ctrl_force <= bus.wdata[sws_pkg::CTRL_FORCE];
      end
      irq <= |(next_status & mask);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !bus.rd) begin
      rd_data <= 32'h0;
    end else begin
      case (bus.addr)
        sws_pkg::ADDR_CTRL: rd_data <= {31'h0, ctrl_force};
        sws_pkg::ADDR_STATE: rd_data <= {21'h0, sel_lat, wcode, rcode, wdet_done, rdet_done,
                                         active, ~watchdog_fault_out_oe_n, ~reset_pin_oe_n};
        sws_pkg::ADDR_STATUS: rd_data <= {28'h0, status};
        sws_pkg::ADDR_MASK: rd_data <= {28'h0, mask};
        default: rd_data <= 32'h0;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_lockout_holds_reset: assert property (supply_s |=> !reset_pin_oe_n) // R1
    else $error("reset released during supply lockout");
  a_reset_floats_fault: assert property (!reset_pin_oe_n |-> watchdog_fault_out_oe_n) // R2
    else $error("fault output driven while reset asserted");
  a_sense_fault_reset: assert property ((under_s || over_s) |=> !reset_pin_oe_n) // R3
    else $error("reset not asserted for sense outside window");
  a_early_kick_fault: assert property (early && !fault_cond |=> !watchdog_fault_out_oe_n) // R4
    else $error("early kick did not raise fault");
  a_late_kick_fault: assert property (active && !kick_fall && wd_cnt == upper - 1 && !fault_cond
    |=> !watchdog_fault_out_oe_n) // R4
    else $error("missed kick did not raise fault");
  a_delay_length: assert property (state == ST_RUN && $past(state) == ST_DELAY
    |-> $past(dly_cnt) == $past(dly_cyc) - 1) // R5
    else $error("reset delay length wrong");
  a_cap_discharge: assert property (reset_cap_discharge |-> !reset_pin_oe_n) // R7
    else $error("capacitor discharged with reset released");
  a_first_kick_free: assert property (active && kick_fall && wd_first && !fault_cond
    && watchdog_fault_out_oe_n |=> watchdog_fault_out_oe_n) // R12
    else $error("first kick checked against lower bound");
  a_sel_hold_run: assert property (state == ST_RUN && $past(state) == ST_RUN
    && $past(sel_lat) != sws_pkg::SEL_DIS && $past(wd_live_en) |-> $stable(sel_lat)) // R13
    else $error("window timing changed without reset");
  a_settle_load: assert property (wd_live_en && !wd_en_q |=> settle_cnt == P_SETUP) // R14
    else $error("settling period not started");
  a_redetect_window: assert property (win_entry |=> !wdet_done) // R15
    else $error("timing pin not re-detected");

  c_reset_release: cover property ($rose(reset_pin_oe_n));
  c_early_fault: cover property (early);
  c_late_fault: cover property (late);
  c_good_kick: cover property (active && kick_fall && !wd_first && !early);
endmodule : sws_supervisor

// ---- hdl/sws_sync3.sv ----
// Purpose: Three-stage synchroniser for asynchronous pin levels.
// Assumes: Inputs are slow levels compared with the clock.
// Notes: A bit changes only once the second and third stages agree.
`timescale 1ns/1ps
module sws_sync3 #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ff1 <= '0;
      ff2 <= '0;
      ff3 <= '0;
      q <= '0;
    end else begin
      ff1 <= d;
      ff2 <= ff1;
      ff3 <= ff2;
      q <= (ff3 & ~(ff2 ^ ff3)) | (q & (ff2 ^ ff3));
    end
  end
endmodule : sws_sync3

// ---- tb/sws_host_model.sv ----
// Purpose: Host processor model that kicks the watchdog at a set period.
// Assumes: Period in clock cycles, at least 2.
// Notes: The kick line is always driven to a full level, never left floating.
`timescale 1ns/1ps
module sws_host_model (
  input wire logic clk_sys,
  input wire logic run,
  input wire logic [15:0] period,
  output logic kick
);
  logic [15:0] cnt;
  // The first falling edge comes half a period after starting, well inside any upper bound.
  always_ff @(posedge clk_sys) begin
    if (!run || cnt >= period - 16'h1) begin
      cnt <= 16'h0;
    end else begin
      cnt <= cnt + 16'h1;
    end
    kick <= !run || (cnt < (period >> 1));
  end
endmodule : sws_host_model

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the supervisor window watchdog.
// Assumes: Shortened counts: delay 200/100, detect 20, window 40 to 100 cycles.
// Notes: Pin inputs pass a synchroniser, so waits carry a few cycles of margin.
`timescale 1ns/1ps
module testbench;
  localparam sws_pkg::sws_cnt_t LO = 36'h28;
  localparam sws_pkg::sws_cnt_t HI = 36'h64;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  sws_pkg::sws_bus_req_t bus = '0;
  logic [31:0] rd_data, s;
  logic lock = 1'b1, below = 1'b0, above = 1'b0, kick, sel0 = 1'b0, sel1 = 1'b0;
  logic [1:0] rcfg = 2'h0, wcfg = 2'h0;
  logic rst_oe_n, fault_oe_n, irq, rst_out, wdo_out, cap_dis, run = 1'b0;
  logic [15:0] period = 16'h46;
  int miscompares = 0, checks = 0, cyc = 0;
  always #5 clk_sys = ~clk_sys;
  sws_host_model i_host (.clk_sys(clk_sys), .run(run), .period(period), .kick(kick));
  sws_supervisor #(.P_RST_OPEN(36'hc8), .P_RST_PULL(36'h64), .P_RST_CAP(36'h96),
    .P_DET(36'h14), .P_SETUP(36'hf), .P_WDU_CAP(HI),
    .P_WDL_O00(LO), .P_WDU_O00(HI), .P_WDL_O01(LO), .P_WDU_O01(HI),
    .P_WDL_O11(LO), .P_WDU_O11(HI), .P_WDL_P00(LO), .P_WDU_P00(HI),
    .P_WDL_P01(LO), .P_WDU_P01(HI), .P_WDL_P11(LO), .P_WDU_P11(HI)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .bus(bus), .rd_data(rd_data),
    .supply_below_lockout(lock), .sense_below_window(below), .sense_above_window(above),
    .watchdog_kick_in(kick), .window_select_0(sel0), .window_select_1(sel1),
    .reset_delay_cfg_pin(rcfg), .watchdog_timing_cfg_pin(wcfg),
    .reset_pin_out(rst_out), .reset_pin_oe_n(rst_oe_n), .watchdog_fault_out(wdo_out),
    .watchdog_fault_out_oe_n(fault_oe_n), .reset_cap_discharge(cap_dis), .irq(irq));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic pin(input bit f);
    return f ? fault_oe_n : rst_oe_n;
  endfunction : pin
  task automatic wait_pin(input string n, input bit f, input logic v, input int lim);
    for (int k = 0; k < lim && pin(f) !== v; k++) @(posedge clk_sys);
    chk(n, {31'h0, v}, {31'h0, pin(f)});
  endtask : wait_pin
  // Any single deviation over the span is reported once.
  task automatic hold_pin(input string n, input bit f, input logic v, input int cnt);
    int k;
    for (k = 0; k < cnt && pin(f) === v; k++) @(posedge clk_sys);
    chk(n, {31'h0, v}, {31'h0, pin(f)});
  endtask : hold_pin
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
    @(posedge clk_sys);
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    #1 d = rd_data;
    @(posedge clk_sys);
  endtask : bus_rd

  task automatic t_lockout();
    run <= 1'b1;
    period <= 16'ha;
    hold_pin("reset_lockout", 0, 1'b0, 300);
    chk("fault_lockout", 32'h1, {31'h0, fault_oe_n});
    run <= 1'b0;
  endtask : t_lockout
  task automatic t_release_and_kick();
    lock <= 1'b0;
    hold_pin("reset_delay_open", 0, 1'b0, 195);
    wait_pin("reset_release", 0, 1'b1, 40);
    period <= 16'h46;
    run <= 1'b1;
    hold_pin("fault_good", 1, 1'b1, 500);
    bus_wr(sws_pkg::ADDR_MASK, 32'hf);
    run <= 1'b0;
    wait_pin("fault_late", 1, 1'b0, 120);
    bus_rd(sws_pkg::ADDR_STATUS, s);
    chk("status_late", 32'h1, {31'h0, s[sws_pkg::EV_LATE]});
    bus_wr(sws_pkg::ADDR_STATUS, 32'hf);
    chk("irq_off", 32'h0, {31'h0, irq});
    run <= 1'b1;
    wait_pin("fault_recover", 1, 1'b1, 300);
    hold_pin("fault_first", 1, 1'b1, 300);
  endtask : t_release_and_kick
  task automatic t_early_and_irq();
    period <= 16'h14;
    wait_pin("fault_early", 1, 1'b0, 60);
    chk("irq_on", 32'h1, {31'h0, irq});
    run <= 1'b0;
    bus_wr(sws_pkg::ADDR_MASK, 32'h0);
    bus_rd(sws_pkg::ADDR_STATUS, s);
    chk("status_early", 32'h1, {31'h0, s[sws_pkg::EV_EARLY]});
    chk("irq_masked", 32'h0, {31'h0, irq});
    bus_wr(sws_pkg::ADDR_STATUS, 32'hf);
    bus_rd(sws_pkg::ADDR_STATUS, s);
    chk("status_clear", 32'h0, {31'h0, s[sws_pkg::EV_EARLY]});
    bus_rd(8'h10, s);
    chk("unmapped", 32'h0, s);
  endtask : t_early_and_irq
  task automatic t_disable();
    sel0 <= 1'b1;
    wait_pin("fault_disable", 1, 1'b1, 250);
    hold_pin("fault_disabled", 1, 1'b1, 400);
    sel0 <= 1'b0;
    period <= 16'h46;
    run <= 1'b1;
    hold_pin("fault_enable", 1, 1'b1, 300);
  endtask : t_disable
  task automatic t_overvolt();
    above <= 1'b1;
    rcfg <= 2'h1;
    wcfg <= 2'h1;
    wait_pin("reset_over", 0, 1'b0, 10);
    chk("fault_float", 32'h1, {31'h0, fault_oe_n});
    above <= 1'b0;
    hold_pin("reset_delay_pull", 0, 1'b0, 95);
    wait_pin("reset_pull_release", 0, 1'b1, 60);
  endtask : t_overvolt
  // The software hold keeps reset asserted long enough for the capacitor class to latch.
  task automatic t_force_cap();
    below <= 1'b1;
    rcfg <= 2'h2;
    wait_pin("reset_under", 0, 1'b0, 10);
    chk("reset_out_low", 32'h0, {31'h0, rst_out});
    chk("fault_out_low", 32'h0, {31'h0, wdo_out});
    bus_wr(sws_pkg::ADDR_CTRL, 32'h1);
    below <= 1'b0;
    repeat (30) @(posedge clk_sys);
    chk("cap_discharge", 32'h1, {31'h0, cap_dis});
    bus_rd(sws_pkg::ADDR_CTRL, s);
    chk("ctrl_force", 32'h1, s);
    bus_rd(sws_pkg::ADDR_STATE, s);
    chk("state_rcode", 32'h2, {30'h0, s[6:5]});
    bus_wr(sws_pkg::ADDR_CTRL, 32'h0);
    @(posedge clk_sys);
    chk("cap_charge", 32'h0, {31'h0, cap_dis});
    hold_pin("reset_delay_cap", 0, 1'b0, 145);
    wait_pin("reset_cap_release", 0, 1'b1, 20);
  endtask : t_force_cap

  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_lockout();
    t_release_and_kick();
    t_early_and_irq();
    t_disable();
    t_overvolt();
    t_force_cap();
    test_done();
  end
endmodule : testbench
